// >>> ddrrd_apb.sv
`timescale 1ns/1ps
`include "ddrrd_consts.svh"

module ddrrd_apb
    import ddrrd_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Core state
    input wire logic [6:0] init_state,
    input wire logic [3:0] open_banks,
    input wire logic [3:0] debt,
    input wire logic [12:0] mode,
    input wire logic [12:0] emode,
    input wire logic [2:0] err_set,
    // Data store port
    input wire logic [15:0] mem_rdata,
    output logic [5:0] mem_addr,
    output logic mem_we,
    output logic [15:0] mem_wdata
);

    ddrrd_apb_t q;
    ddrrd_apb_t n;
    logic setup;
    logic acc;
    logic mapped;

    always_comb
    begin
        n = q;
        setup = psel & ~penable;
        acc = psel & penable;
        mapped = 1'b1;
        case (paddr)
            `DDRRD_REG_MEM_ADDR, `DDRRD_REG_MEM_DATA, `DDRRD_REG_STATUS, `DDRRD_REG_MODE, `DDRRD_REG_ERR:
                mapped = 1'b1;
            default:
                mapped = 1'b0;
        endcase
        // Read data is latched in the setup cycle so prdata comes from a flop
        if (setup)
        begin
            case (paddr)
                `DDRRD_REG_MEM_ADDR: n.prdata = {26'h0000000, q.maddr};
                `DDRRD_REG_MEM_DATA: n.prdata = {16'h0000, mem_rdata};
                `DDRRD_REG_STATUS: n.prdata = {16'h0000, debt, open_banks, 1'b0, init_state};
                `DDRRD_REG_MODE: n.prdata = {3'h0, emode, 3'h0, mode};
                `DDRRD_REG_ERR: n.prdata = {29'h00000000, q.err};
                default: n.prdata = 32'h00000000;
            endcase
        end
        if (acc && pwrite)
        begin
            case (paddr)
                `DDRRD_REG_MEM_ADDR: n.maddr = pwdata[5:0];
                `DDRRD_REG_MEM_DATA: n.maddr = q.maddr + 6'h01;
                `DDRRD_REG_ERR: n.err = q.err & ~pwdata[2:0];
                default: n.maddr = q.maddr;
            endcase
        end
        // Set after clear so a same-cycle event survives
        n.err = n.err | err_set;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            q <= '0;
        else
            q <= n;
    end

    assign prdata = q.prdata;
    assign pready = 1'b1;
    assign pslverr = acc & ~mapped;
    assign mem_addr = q.maddr;
    assign mem_we = acc & pwrite & (paddr == `DDRRD_REG_MEM_DATA);
    assign mem_wdata = pwdata[15:0];

endmodule

// >>> ddrrd_consts.svh
`ifndef DDRRD_CONSTS_SVH
`define DDRRD_CONSTS_SVH

// Clock rate and timing
`define DDRRD_CLK_MHZ 200
`define DDRRD_T_STABLE_US 200
`define DDRRD_STABLE_CYC (`DDRRD_T_STABLE_US * `DDRRD_CLK_MHZ)
`define DDRRD_DLL_LOCK_CYC 200
`define DDRRD_T_MRD_NS 10
`define DDRRD_MRD_CYC ((`DDRRD_T_MRD_NS * `DDRRD_CLK_MHZ + 999) / 1000)
`define DDRRD_T_REFI_NS 7800
`define DDRRD_REFI_CYC ((`DDRRD_T_REFI_NS * `DDRRD_CLK_MHZ) / 1000)
`define DDRRD_MAX_POSTED 4'h8
`define DDRRD_MIN_INIT_AR 2'h2

// Register byte offsets
`define DDRRD_REG_MEM_ADDR 8'h00
`define DDRRD_REG_MEM_DATA 8'h04
`define DDRRD_REG_STATUS 8'h08
`define DDRRD_REG_MODE 8'h0C
`define DDRRD_REG_ERR 8'h10

// Status and mode register field positions
`define DDRRD_ST_OPEN_LSB 8
`define DDRRD_ST_DEBT_LSB 12
`define DDRRD_MODE_EXT_LSB 16

// Address bit fields of mode register loads and column commands
`define DDRRD_A_AP 10
`define DDRRD_A_DLL_RST 8
`define DDRRD_A_BT 3
`define DDRRD_EMR_DLL_DIS 0
`define DDRRD_BA_MODE 2'h0
`define DDRRD_BA_EXT 2'h1

// Burst length and CAS latency codes
`define DDRRD_BL2 3'h1
`define DDRRD_BL4 3'h2
`define DDRRD_BL8 3'h3
`define DDRRD_CL2 3'h2
`define DDRRD_CL3 3'h3
`define DDRRD_CL25 3'h6

// Reset values
`define DDRRD_MODE_RST 13'h0032
`define DDRRD_EMODE_RST 13'h0000

`endif

// >>> ddrrd_ctl_model.sv
`timescale 1ns/1ps
module ddrrd_ctl_model (
    // Clock
    input wire logic pclk,
    // Command pins
    output logic cke,
    output logic cs_n,
    output logic [2:0] rcw,
    output logic [1:0] ba,
    output logic [12:0] addr
);
    initial
    begin
        cke = 1'b0;
        cs_n = 1'b0;
        rcw = 3'h7;
        ba = 2'h0;
        addr = 13'h0000;
    end
    task automatic cmd(input logic [2:0] c, logic [1:0] b, logic [12:0] a, logic s = 1'b0);
        @(posedge pclk);
        cke <= 1'b1;
        cs_n <= s;
        rcw <= c;
        ba <= b;
        addr <= a;
    endtask
    task automatic idle(input int n);
        repeat (n) cmd(3'h7, 2'h0, 13'h0000);
    endtask
    task automatic init(input int stable, input logic [12:0] mode);
        repeat (stable + 2) @(posedge pclk);
        idle(1);
        cmd(3'h2, 2'h0, 13'h0400);
        idle(1);
        cmd(3'h0, 2'h1, 13'h0000);
        idle(1);
        cmd(3'h0, 2'h0, 13'h0122);
        idle(200);
        cmd(3'h2, 2'h0, 13'h0400);
        idle(1);
        cmd(3'h1, 2'h0, 13'h0000);
        idle(14);
        cmd(3'h1, 2'h0, 13'h0000);
        idle(14);
        cmd(3'h0, 2'h0, mode);
        idle(1);
    endtask
endmodule

// >>> ddrrd_pipe.sv
`timescale 1ns/1ps
`include "ddrrd_consts.svh"

module ddrrd_pipe
    import ddrrd_pkg::*;
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Pairs from the burst generator
    input wire logic gen_v,
    input wire logic [15:0] gen_d0,
    input wire logic [15:0] gen_d1,
    input wire logic [2:0] cl,
    // Double-rate read data
    output logic [15:0] dq_rise,
    output logic [15:0] dq_fall,
    output logic dq_oe_n,
    output logic dqs_rise,
    output logic dqs_fall,
    output logic dqs_oe_n
);

    ddrrd_pipe_t q;
    ddrrd_pipe_t n;
    logic rv;
    logic fv;
    logic look;
    logic half;
    logic [15:0] rd;
    logic [15:0] fd;

    always_comb
    begin
        n = q;
        n.p0v = gen_v;
        n.p0d0 = gen_d0;
        n.p0d1 = gen_d1;
        n.p1v = q.p0v;
        n.p1d0 = q.p0d0;
        n.p1d1 = q.p0d1;
        half = 1'b0;
        // Half-cycle latency reuses the previous pair's falling element
        unique case (cl)
            `DDRRD_CL2:
            begin
                rv = q.p0v;
                rd = q.p0d0;
                fv = q.p0v;
                fd = q.p0d1;
                look = gen_v;
            end
            `DDRRD_CL25:
            begin
                rv = q.p1v;
                rd = q.p1d1;
                fv = q.p0v;
                fd = q.p0d0;
                look = gen_v;
                half = 1'b1;
            end
            default:
            begin
                rv = q.p1v;
                rd = q.p1d0;
                fv = q.p1v;
                fd = q.p1d1;
                look = q.p0v;
            end
        endcase
        n.dq_rise = rv ? rd : 16'h0000;
        n.dq_fall = fv ? fd : 16'h0000;
        n.dq_oe_n = ~(rv | fv);
        // Strobe low one cycle ahead of data is the preamble
        n.dqs_oe_n = ~(rv | fv | look); // R20
        n.dqs_rise = ~half & rv; // R20
        n.dqs_fall = half & fv; // R20
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            q <= '{dq_oe_n: 1'b1, dqs_oe_n: 1'b1, default: '0};
        else
            q <= n;
    end

    assign dq_rise = q.dq_rise;
    assign dq_fall = q.dq_fall;
    assign dq_oe_n = q.dq_oe_n;
    assign dqs_rise = q.dqs_rise;
    assign dqs_fall = q.dqs_fall;
    assign dqs_oe_n = q.dqs_oe_n;

endmodule

// >>> ddrrd_pkg.sv
package ddrrd_pkg;

    typedef enum logic [6:0] {
        S_POWER = 7'h01,
        S_PREA1 = 7'h02,
        S_EMRS = 7'h04,
        S_MRSRST = 7'h08,
        S_PREA2 = 7'h10,
        S_REFR = 7'h20,
        S_READY = 7'h40
    } ddrrd_init_t;

    typedef enum logic [7:0] {
        C_NOP = 8'h01,
        C_ACT = 8'h02,
        C_READ = 8'h04,
        C_WRITE = 8'h08,
        C_BST = 8'h10,
        C_PRE = 8'h20,
        C_AR = 8'h40,
        C_MRS = 8'h80
    } ddrrd_cmd_t;

    typedef struct packed {
        ddrrd_init_t st;
        logic [31:0] wait_cnt;
        logic [7:0] lock_cnt;
        logic [1:0] mrd_cnt;
        logic [1:0] ar_cnt;
        logic [12:0] mode;
        logic [12:0] emode;
        logic [3:0] open;
        logic [10:0] refi_cnt;
        logic [3:0] debt;
        logic bst_act;
        logic [2:0] bst_i;
        logic [1:0] bst_ba;
        logic [9:0] bst_col;
        logic bst_ap;
        logic gen_v;
        logic [15:0] gen_d0;
        logic [15:0] gen_d1;
        logic ev_init;
        logic ev_over;
        logic ev_closed;
    } ddrrd_core_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic [5:0] maddr;
        logic [2:0] err;
    } ddrrd_apb_t;

    typedef struct packed {
        logic p0v;
        logic [15:0] p0d0;
        logic [15:0] p0d1;
        logic p1v;
        logic [15:0] p1d0;
        logic [15:0] p1d1;
        logic [15:0] dq_rise;
        logic [15:0] dq_fall;
        logic dq_oe_n;
        logic dqs_rise;
        logic dqs_fall;
        logic dqs_oe_n;
    } ddrrd_pipe_t;

endpackage

// >>> ddrrd_props.sv
`timescale 1ns/1ps
module ddrrd_props (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Command pins
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [1:0] ba,
    input wire logic [12:0] addr,
    // Read data
    input wire logic dq_oe_n,
    input wire logic dqs_rise,
    input wire logic dqs_fall,
    input wire logic dqs_oe_n
);
    logic [2:0] cmd;
    logic rd;
    logic [2:0] cl_q;
    logic [2:0] bl_q;
    logic dr_q;
    logic rdy_q;
    assign cmd = (cke && !cs_n) ? {ras_n, cas_n, we_n} : 3'h7;
    assign rd = rdy_q && cmd == 3'h5;
    // Ready only once the loop-reset load has been cleared
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cl_q <= 3'h2;
            bl_q <= 3'h2;
            dr_q <= 1'b0;
            rdy_q <= 1'b0;
        end
        else if (cmd == 3'h0 && ba == 2'h0)
        begin
            cl_q <= addr[6:4];
            bl_q <= addr[2:0];
            dr_q <= dr_q | addr[8];
            rdy_q <= rdy_q | (dr_q & !addr[8]);
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    sequence s_nop;
        cmd == 3'h7;
    endsequence
    sequence s_rd2(b);
        rd && cl_q == 3'h2 && bl_q == b;
    endsequence
    a_cl2_lead: assert property (rd && cl_q == 3'h2 |-> ##2 !dqs_oe_n ##1 (!dq_oe_n && dqs_rise && !dqs_fall))
        else $error("latency two late");
    a_cl3_lead: assert property (rd && cl_q == 3'h3 |-> ##3 !dqs_oe_n ##1 !dq_oe_n)
        else $error("latency three late");
    a_cl25_lead: assert property (rd && cl_q == 3'h6 |-> ##2 !dqs_oe_n ##1 (!dq_oe_n && dqs_fall))
        else $error("latency 2.5 late");
    a_bl4_len: assert property (s_rd2(3'h2) ##1 s_nop[*2] |-> ##1 !dq_oe_n[*2] ##1 dq_oe_n)
        else $error("burst four length");
    a_seam_join: assert property (s_rd2(3'h2) ##1 s_nop ##1 rd |-> ##1 !dq_oe_n[*4])
        else $error("gap between bursts");
    a_bl2_run: assert property (s_rd2(3'h1) ##1 rd ##1 s_nop |-> ##1 !dq_oe_n[*2] ##1 dq_oe_n)
        else $error("short bursts wrong");
    a_bst_cut: assert property (s_rd2(3'h3) ##1 s_nop ##1 cmd == 3'h6 |-> ##1 !dq_oe_n[*2] ##1 dq_oe_n)
        else $error("terminate ignored");
    a_strobe_data: assert property (!dq_oe_n |-> !dqs_oe_n)
        else $error("data driven without strobe");
endmodule
bind ddrrd_top ddrrd_props u_props (
    .pclk(pclk), .presetn(presetn), .cke(cke), .cs_n(cs_n), .ras_n(ras_n), .cas_n(cas_n), .we_n(we_n),
    .ba(ba), .addr(addr), .dq_oe_n(dq_oe_n), .dqs_rise(dqs_rise), .dqs_fall(dqs_fall), .dqs_oe_n(dqs_oe_n)
);

// >>> ddrrd_top.sv
// Overview of operation
// R1: Command inputs idle, clock-enable low during power-up.
// R2: Clock stable 200 us before next step.
// R3: No-operation with clock-enable high, then precharge-all.
// R4: Extended mode enables loop, mode resets loop.
// R5: Precharge all, then two or more refreshes. The code also counts refreshes issued before that precharge toward the two.
// R6: Final mode load with A8 low.
// R7: At most eight refreshes postponed, tracked.
// R8: Controller drives write strobe valid at first edge.
// R9: First read data after programmed CAS latency.
// R10: Length four: addressed column then three more.
// R11: Back-to-back reads join; second interrupts length eight.
// R12: Seamless reads target one device only.
// R13: Any open bank; new read interrupts burst.
// R14: Burst terminate stops a read burst early.
// R15: Terminate read before write; length two may idle.
// R16: Wait 10 ns after mode load.
// R17: A10 with read selects auto precharge.
// R18: Precharge no earlier than half burst after read.
// R19: Element order sequential or interleaved within aligned block.
// R20: Strobe edge-aligned with data, one-cycle preamble.
`timescale 1ns/1ps
`include "ddrrd_consts.svh"

module ddrrd_top
    import ddrrd_pkg::*;
#(
    parameter int STABLE_CYC = `DDRRD_STABLE_CYC
)
(
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Command and address from the memory controller
    input wire logic cke,
    input wire logic cs_n,
    input wire logic ras_n,
    input wire logic cas_n,
    input wire logic we_n,
    input wire logic [1:0] ba,
    input wire logic [12:0] addr,
    // Double-rate read data
    output logic [15:0] dq_rise,
    output logic [15:0] dq_fall,
    output logic dq_oe_n,
    output logic dqs_rise,
    output logic dqs_fall,
    output logic dqs_oe_n
);

    localparam int LOCK_CYC = `DDRRD_DLL_LOCK_CYC;
    localparam int MRD_CYC = `DDRRD_MRD_CYC;
    localparam int REFI_CYC = `DDRRD_REFI_CYC;

    function automatic ddrrd_cmd_t cmd_decode(input logic en, input logic sel_n, input logic [2:0] rcw);
        ddrrd_cmd_t c;
        c = C_NOP;
        if (en && !sel_n)
        begin
            unique case (rcw)
                3'h7: c = C_NOP;
                3'h3: c = C_ACT;
                3'h5: c = C_READ;
                3'h4: c = C_WRITE;
                3'h6: c = C_BST;
                3'h2: c = C_PRE;
                3'h1: c = C_AR;
                3'h0: c = C_MRS;
            endcase
        end
        return c;
    endfunction

    function automatic logic [3:0] bl_len(input logic [2:0] code);
        logic [3:0] l;
        case (code)
            `DDRRD_BL2: l = 4'h2;
            `DDRRD_BL4: l = 4'h4;
            `DDRRD_BL8: l = 4'h8;
            default: l = 4'h2;
        endcase
        return l;
    endfunction

    // Wraps inside the block aligned to the burst length
    function automatic logic [9:0] burst_col(input logic [9:0] start, input logic [2:0] i,
                                             input logic [3:0] bl, input logic bt);
        logic [2:0] mask;
        logic [2:0] lo;
        mask = 3'(bl - 4'h1);
        lo = bt ? (start[2:0] ^ i) : 3'(start[2:0] + i); // R19
        return {start[9:3], (lo & mask) | (start[2:0] & ~mask)}; // R19
    endfunction

    ddrrd_core_t q;
    ddrrd_core_t n;
    ddrrd_cmd_t cmd;
    logic [15:0] mem [0:63];
    logic [5:0] mem_addr;
    logic mem_we;
    logic [15:0] mem_wdata;
    logic [15:0] mem_rdata;
    logic [3:0] bl;
    logic go;
    logic [1:0] cur_ba;
    logic [9:0] cur_col;
    logic [2:0] cur_i;
    logic cur_ap;
    logic [3:0] nxt_i;
    logic [9:0] col0;
    logic [9:0] col1;
    logic tick;
    logic dn;
    logic is_mode;
    logic is_ext;

    always_ff @(posedge pclk)
    begin
        if (mem_we)
            mem[mem_addr] <= mem_wdata;
    end

    assign mem_rdata = mem[mem_addr];

    always_comb
    begin
        n = q;
        cmd = cmd_decode(cke, cs_n, {ras_n, cas_n, we_n});
        bl = bl_len(q.mode[2:0]);
        is_mode = (cmd == C_MRS) && (ba == `DDRRD_BA_MODE);
        is_ext = (cmd == C_MRS) && (ba == `DDRRD_BA_EXT);
        n.ev_init = 1'b0;
        n.ev_over = 1'b0;
        n.ev_closed = 1'b0;
        n.gen_v = 1'b0;
        go = 1'b0;
        cur_ba = q.bst_ba;
        cur_col = q.bst_col;
        cur_i = q.bst_i;
        cur_ap = q.bst_ap;
        nxt_i = 4'h0;
        col0 = 10'h000;
        col1 = 10'h000;
        tick = 1'b0;
        dn = 1'b0;

        // Mode loads and the settle gap after them
        if (q.mrd_cnt != 2'h0)
        begin
            n.mrd_cnt = q.mrd_cnt - 2'h1;
            if (cmd != C_NOP)
                n.ev_init = 1'b1; // R16
        end
        if (is_mode)
            n.mode = addr;
        if (is_ext)
            n.emode = addr;
        if (cmd == C_MRS)
            n.mrd_cnt = 2'(MRD_CYC - 1); // R16
        if (q.lock_cnt != 8'h00)
            n.lock_cnt = q.lock_cnt - 8'h01;

        // Start-up sequence tracking; a step out of order is flagged
        unique case (q.st)
            S_POWER:
            begin
                if (q.wait_cnt != 32'hFFFFFFFF)
                    n.wait_cnt = q.wait_cnt + 32'h1;
                if (cke)
                begin
                    n.st = S_PREA1;
                    if ((q.wait_cnt < 32'(STABLE_CYC)) || (cmd != C_NOP))
                        n.ev_init = 1'b1; // R2 R3
                end
            end
            S_PREA1:
            begin
                if ((cmd == C_PRE) && addr[`DDRRD_A_AP])
                    n.st = S_EMRS; // R3
                else if (cmd != C_NOP)
                    n.ev_init = 1'b1;
            end
            S_EMRS:
            begin
                if (is_ext && !addr[`DDRRD_EMR_DLL_DIS])
                    n.st = S_MRSRST; // R4
                else if (cmd != C_NOP)
                    n.ev_init = 1'b1;
            end
            S_MRSRST:
            begin
                if (is_mode && addr[`DDRRD_A_DLL_RST])
                begin
                    n.st = S_PREA2; // R4
                    n.lock_cnt = 8'(LOCK_CYC);
                    n.ar_cnt = 2'h0;
                end
                else if (cmd != C_NOP)
                    n.ev_init = 1'b1;
            end
            S_PREA2:
            begin
                // Refreshes may also come before this precharge
                if ((cmd == C_PRE) && addr[`DDRRD_A_AP])
                    n.st = S_REFR; // R5
                else if ((cmd == C_AR) && (q.ar_cnt != 2'h3))
                    n.ar_cnt = q.ar_cnt + 2'h1;
                else if ((cmd != C_NOP) && (cmd != C_AR))
                    n.ev_init = 1'b1;
            end
            S_REFR:
            begin
                if ((cmd == C_AR) && (q.ar_cnt != 2'h3))
                    n.ar_cnt = q.ar_cnt + 2'h1; // R5
                else if (is_mode && !addr[`DDRRD_A_DLL_RST])
                begin
                    n.st = S_READY; // R6
                    if ((q.ar_cnt < `DDRRD_MIN_INIT_AR) || (q.lock_cnt != 8'h00))
                        n.ev_init = 1'b1; // R4 R5
                end
                else if ((cmd != C_NOP) && (cmd != C_AR))
                    n.ev_init = 1'b1;
            end
            S_READY:
            begin
                n.st = S_READY;
            end
            default:
            begin
                n.st = S_POWER;
            end
        endcase

        // Open rows per bank
        if (q.st == S_READY)
        begin
            if (cmd == C_ACT)
                n.open[ba] = 1'b1;
            if (cmd == C_PRE)
            begin
                if (addr[`DDRRD_A_AP])
                    n.open = 4'h0;
                else
                    n.open[ba] = 1'b0;
            end
        end

        // Burst generator: one element pair per clock
        if (cmd == C_BST)
            n.bst_act = 1'b0; // R14 R15
        else if ((cmd == C_READ) && (q.st == S_READY))
        begin
            go = 1'b1; // R11 R13
            cur_ba = ba;
            cur_col = addr[9:0];
            cur_i = 3'h0;
            cur_ap = addr[`DDRRD_A_AP]; // R17
            if (!q.open[ba])
                n.ev_closed = 1'b1; // R13
            // A burst with auto precharge cut by a new read still closes its row
            if (q.bst_act && q.bst_ap)
                n.open[q.bst_ba] = 1'b0;
        end
        else if (q.bst_act)
            go = 1'b1;

        if (go)
        begin
            col0 = burst_col(cur_col, cur_i, bl, q.mode[`DDRRD_A_BT]); // R10 R19
            col1 = burst_col(cur_col, 3'(cur_i + 3'h1), bl, q.mode[`DDRRD_A_BT]); // R10 R19
            n.gen_v = 1'b1; // R9
            n.gen_d0 = mem[{cur_ba, col0[3:0]}];
            n.gen_d1 = mem[{cur_ba, col1[3:0]}];
            nxt_i = {1'b0, cur_i} + 4'h2;
            n.bst_ba = cur_ba;
            n.bst_col = cur_col;
            n.bst_ap = cur_ap;
            n.bst_i = nxt_i[2:0];
            if (nxt_i >= bl)
            begin
                n.bst_act = 1'b0;
                if (cur_ap)
                    n.open[cur_ba] = 1'b0; // R17
            end
            else
                n.bst_act = 1'b1;
        end

        // Refresh debt: one interval adds, one refresh pays
        if (q.st == S_READY)
        begin
            if (q.refi_cnt == 11'(REFI_CYC - 1))
            begin
                n.refi_cnt = 11'h000;
                tick = 1'b1;
            end
            else
                n.refi_cnt = q.refi_cnt + 11'h001;
            dn = (cmd == C_AR) && (q.debt != 4'h0);
            if (tick && !dn)
            begin
                if (q.debt == `DDRRD_MAX_POSTED)
                    n.ev_over = 1'b1; // R7
                else
                    n.debt = q.debt + 4'h1; // R7
            end
            else if (dn && !tick)
                n.debt = q.debt - 4'h1; // R7
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            q <= '{st: S_POWER, mode: `DDRRD_MODE_RST, emode: `DDRRD_EMODE_RST, default: '0};
        else
            q <= n;
    end

    ddrrd_apb u_apb (
        .pclk(pclk),
        .presetn(presetn),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .init_state(q.st),
        .open_banks(q.open),
        .debt(q.debt),
        .mode(q.mode),
        .emode(q.emode),
        .err_set({q.ev_closed, q.ev_over, q.ev_init}),
        .mem_rdata(mem_rdata),
        .mem_addr(mem_addr),
        .mem_we(mem_we),
        .mem_wdata(mem_wdata)
    );

    ddrrd_pipe u_pipe (
        .pclk(pclk),
        .presetn(presetn),
        .gen_v(q.gen_v),
        .gen_d0(q.gen_d0),
        .gen_d1(q.gen_d1),
        .cl(q.mode[6:4]),
        .dq_rise(dq_rise),
        .dq_fall(dq_fall),
        .dq_oe_n(dq_oe_n),
        .dqs_rise(dqs_rise),
        .dqs_fall(dqs_fall),
        .dqs_oe_n(dqs_oe_n)
    );

endmodule

// >>> testbench.sv
`timescale 1ns/1ps
module testbench;
    typedef struct {logic [12:0] m; logic [1:0] b; logic [3:0] c;} ddrrd_row_t;
    logic pclk = 1'b0, presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready, pslverr, cke, cs_n, dq_oe_n, dqs_rise, dqs_fall, dqs_oe_n, e;
    logic [2:0] rcw;
    logic [1:0] ba;
    logic [12:0] addr;
    logic [15:0] dq_rise, dq_fall;
    logic [15:0] q[$];
    logic [31:0] r;
    int fails = 0, total_checks = 0;
    ddrrd_row_t rows[5] = '{'{13'h022, 2'h0, 4'h5}, '{13'h03A, 2'h1, 4'h6}, '{13'h063, 2'h0, 4'hB},
        '{13'h02B, 2'h1, 4'h3}, '{13'h031, 2'h0, 4'h9}};
    always #2.5 pclk = ~pclk;
    always @(posedge pclk)
    begin
        if (dq_oe_n === 1'b0)
        begin
            q.push_back(dq_rise);
            q.push_back(dq_fall);
        end
    end
    ddrrd_ctl_model ctl (.pclk(pclk), .cke(cke), .cs_n(cs_n), .rcw(rcw), .ba(ba), .addr(addr));
    ddrrd_top #(.STABLE_CYC(20)) dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .cke(cke), .cs_n(cs_n),
        .ras_n(rcw[2]), .cas_n(rcw[1]), .we_n(rcw[0]), .ba(ba), .addr(addr), .dq_rise(dq_rise),
        .dq_fall(dq_fall), .dq_oe_n(dq_oe_n), .dqs_rise(dqs_rise), .dqs_fall(dqs_fall), .dqs_oe_n(dqs_oe_n)
    );
    task automatic check(input logic [31:0] got, exp);
        total_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, logic [7:0] a, logic [31:0] d = 32'h0);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic mload(input logic [12:0] m);
        ctl.cmd(3'h0, 2'h0, m);
        ctl.idle(1);
        q.delete();
    endtask
    task automatic exp_burst(input logic [12:0] m, logic [1:0] b, logic [3:0] c, int o, n);
        logic [3:0] k, msk;
        msk = 4'((1 << m[2:0]) - 1);
        for (int i = 0; i < n; i++)
        begin
            k = m[3] ? c ^ 4'(i) : (c & ~msk) | ((c + 4'(i)) & msk);
            check(32'(q[i + o]), 32'hA000 | 32'({b, k}));
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    initial
    begin
        #150000;
        fails++;
        $display("[ERR] %0t timeout", $time);
        tally_and_finish;
    end
    initial
    begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, 8'h08);
        check(r, 32'h1);
        apb(1'b0, 8'h0C);
        check(r, 32'h32);
        apb(1'b0, 8'h14);
        check({r[30:0], e}, 32'h1);
        apb(1'b1, 8'h00);
        for (int i = 0; i < 64; i++)
            apb(1'b1, 8'h04, 32'hA000 | 32'(i));
        ctl.init(20, 13'h022);
        apb(1'b0, 8'h08);
        check(r, 32'h40);
        apb(1'b0, 8'h10);
        check(r, 32'h0);
        ctl.cmd(3'h3, 2'h0, 13'h0000);
        ctl.cmd(3'h3, 2'h1, 13'h0000);
        foreach (rows[j])
        begin
            mload(rows[j].m);
            ctl.cmd(3'h5, rows[j].b, {9'h000, rows[j].c});
            ctl.idle(10);
            exp_burst(rows[j].m, rows[j].b, rows[j].c, int'(rows[j].m[6:4] == 3'h6), 1 << rows[j].m[2:0]);
            check(32'(q.size()), 32'((1 << rows[j].m[2:0]) + 2 * int'(rows[j].m[6:4] == 3'h6)));
        end
        mload(13'h022);
        ctl.cmd(3'h5, 2'h0, 13'h0000);
        ctl.idle(1);
        ctl.cmd(3'h5, 2'h1, 13'h0004);
        ctl.idle(10);
        exp_burst(13'h022, 2'h0, 4'h0, 0, 4);
        exp_burst(13'h022, 2'h1, 4'h4, 4, 4);
        check(32'(q.size()), 32'h8);
        mload(13'h023);
        ctl.cmd(3'h5, 2'h0, 13'h0002);
        ctl.idle(1);
        ctl.cmd(3'h6, 2'h0, 13'h0000);
        ctl.cmd(3'h4, 2'h0, 13'h0000);
        ctl.idle(10);
        exp_burst(13'h023, 2'h0, 4'h2, 0, 4);
        check(32'(q.size()), 32'h4);
        mload(13'h021);
        ctl.cmd(3'h5, 2'h0, 13'h0001);
        ctl.cmd(3'h5, 2'h1, 13'h0006);
        ctl.cmd(3'h5, 2'h0, 13'h0002, 1'b1);
        ctl.idle(10);
        exp_burst(13'h021, 2'h0, 4'h1, 0, 2);
        exp_burst(13'h021, 2'h1, 4'h6, 2, 2);
        check(32'(q.size()), 32'h4);
        ctl.cmd(3'h3, 2'h2, 13'h0000);
        ctl.idle(3);
        apb(1'b0, 8'h08);
        check(32'(r[11:8]), 32'h7);
        ctl.cmd(3'h5, 2'h2, 13'h0400);
        ctl.idle(10);
        apb(1'b0, 8'h08);
        check(32'(r[11:8]), 32'h3);
        ctl.idle(14100);
        apb(1'b0, 8'h08);
        check(32'(r[15:12]), 32'h8);
        apb(1'b0, 8'h10);
        check(32'(r[1]), 32'h1);
        apb(1'b1, 8'h10, 32'h2);
        ctl.cmd(3'h1, 2'h0, 13'h0000);
        ctl.idle(3);
        apb(1'b0, 8'h08);
        check(32'(r[15:12]), 32'h7);
        apb(1'b0, 8'h10);
        check(32'(r[1]), 32'h0);
        tally_and_finish;
    end
endmodule
